// [cpld_pkg.sv]
// package: configuration layout and constants for the cpld macrocell logic
`default_nettype none
package cpld_pkg;
    // ========================================================================
    // sizes
    localparam int CPLD_NUM_TERMS   = 5;
    localparam int CPLD_NUM_MC      = 32;
    localparam int CPLD_NUM_DIN     = 4;
    localparam int CPLD_NUM_GCLK    = 3;
    localparam int CPLD_BLK_INPUTS  = 40;
    localparam int CPLD_REGION_SIZE = 4;
    localparam int CPLD_SIG_W       = 16;
    localparam int CPLD_GBUS_W      = 2 * CPLD_NUM_MC + CPLD_NUM_DIN;
    localparam int CPLD_SEL_W       = 7;
    localparam int CPLD_MAX_CASCADE = 40;
    localparam int CPLD_FOLD_FANIN  = 9;

    // ========================================================================
    // apb register map (byte addresses)
    localparam logic [7:0] CPLD_ADDR_MODE   = 8'h00;
    localparam logic [7:0] CPLD_ADDR_SEL0   = 8'h04;
    localparam logic [7:0] CPLD_ADDR_SEL1   = 8'h08;
    localparam logic [7:0] CPLD_ADDR_STATUS = 8'h0c;
    localparam logic [7:0] CPLD_ADDR_SIG    = 8'h10;
    localparam logic [7:0] CPLD_ADDR_FUSE   = 8'h14;
    localparam logic [7:0] CPLD_ADDR_TMASK  = 8'h20;
    localparam logic [31:0] CPLD_MODE_RST   = 32'h0000_0000;
    localparam logic [31:0] CPLD_SEL_RST    = 32'h0000_0000;
    localparam logic [31:0] CPLD_TMASK_RST  = 32'h0000_0000;
    localparam logic [15:0] CPLD_SIG_RST    = 16'h0000;

    // ========================================================================
    // enumerations
    typedef enum logic [3:0] {
        CPLD_FF_D     = 4'b0001,
        CPLD_FF_T     = 4'b0010,
        CPLD_FF_JK    = 4'b0100,
        CPLD_FF_LATCH = 4'b1000
    } cpld_ff_mode_t;

    typedef logic [1:0] cpld_sel2_t;
    localparam cpld_sel2_t CPLD_XOR_LOW  = 2'd0;
    localparam cpld_sel2_t CPLD_XOR_HIGH = 2'd1;
    localparam cpld_sel2_t CPLD_XOR_PT   = 2'd2;
    localparam cpld_sel2_t CPLD_DIN_XOR  = 2'd0;
    localparam cpld_sel2_t CPLD_DIN_PT   = 2'd1;
    localparam cpld_sel2_t CPLD_DIN_PIN  = 2'd2;
    localparam cpld_sel2_t CPLD_CLR_OFF  = 2'd0;
    localparam cpld_sel2_t CPLD_CLR_GLB  = 2'd1;
    localparam cpld_sel2_t CPLD_CLR_PT   = 2'd2;
    localparam cpld_sel2_t CPLD_CLR_BOTH = 2'd3;

    // mode register layout
    typedef struct packed {
        logic [3:0]    rsvd;
        logic          cascade_en;
        logic          fold_sum_en;
        logic [2:0]    oe_src;
        logic          oe_invert;
        logic          fb_reg;
        logic          out_reg;
        logic          preset_en;
        cpld_sel2_t    async_reset_select;
        logic          ce_en;
        logic [2:0]    clk_src;
        cpld_sel2_t    din_src;
        cpld_sel2_t    xor_src;
        logic [4:0]    or_mask;
        cpld_ff_mode_t ff_mode;
    } cpld_mode_t;

    // pin group carrier
    typedef struct packed {
        logic [CPLD_NUM_GCLK-1:0] global_clock_pins;
        logic                     global_clear;
        logic [1:0]               oe_pins;
    } cpld_ctrl_t;
endpackage : cpld_pkg
`default_nettype wire

// [cpld_macrocell.sv]
// macrocell with term select mux, or/xor/cascade, register, feedback and oe selection
`default_nettype none
// Contract
// - five product terms from global and regional bus
// - term select mux allocates terms by config
// - five-term sum, cascade extends to forty
// - xor second input: term, high, low
// - t emulated through xor, jk built from two terms
// - register data: xor, term or pin
// - latch mode transparent while clock high
// - clock from three globals or term
// - term clock enable gates global clock
// - clear: global, term, both, or off
// - preset: term or off only
// - output and feedback independently registered/combinatorial
// - output enable mux from several sources
// - pin may be input; logic stays usable
// - global bus; switch picks forty signals
// - foldback is inverse of one term
// - foldback sum of up to four terms
// - dedicated inputs act as global controls
// - signature readable even with security fuse
module cpld_macrocell
    import cpld_pkg::*;
#(
    parameter int NUM_TERMS = CPLD_NUM_TERMS,
    parameter int GBUS_W    = CPLD_GBUS_W,
    parameter int BLK_IN    = CPLD_BLK_INPUTS
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              clk_en,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire cpld_ctrl_t        ctrl_pins,
    input  wire logic [GBUS_W-1:0] global_bus,
    input  wire logic [2:0]        regional_fold_in,
    input  wire logic              cascade_in,
    input  wire logic [1:0]        oe_extra_in,
    output logic                   cascade_out,
    output logic                   fold_out,
    output logic                   feedback_out,
    output logic                   io_out,
    output logic                   io_oe,
    input  wire logic              io_in
);

    // ========================================================================
    // apb register file
    // 0x00 mode, 0x04 selects, 0x08 fold mask, 0x0c status, 0x10 signature
    // 0x14 fuse: once set only a reset clears it
    // 0x20 + 4i mask i, 0x34 + 4i polarity i, 0xc0 + 4k route k
    // an 8-bit address reaches only the first sixteen routes
    cpld_mode_t              mode_q;
    logic [31:0]             sel0_q, sel1_q;
    logic [BLK_IN-1:0]       tmask_q [NUM_TERMS];
    logic [BLK_IN-1:0]       tpol_q  [NUM_TERMS];
    logic [CPLD_SIG_W-1:0]   sig_q;
    logic                    fuse_q;
    logic                    reg_q;
    logic                    wr_en;
    logic                    rd_en;

    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && penable && !pwrite;
    assign pready  = 1'b1;

    function automatic logic addr_is_term(input logic [7:0] a, output int idx);
        idx = 0;
        addr_is_term = 1'b0;
        for (int i = 0; i < 2 * NUM_TERMS; i++) begin
            if (a == CPLD_ADDR_TMASK + 8'(4 * i)) begin
                addr_is_term = 1'b1;
                idx = i;
            end
        end
    endfunction

    // masks are wider than a word: upper inputs keep a cleared mask, so are ignored
    function automatic logic [31:0] term_word(input int idx);
        logic [BLK_IN-1:0] w;
        if (idx < NUM_TERMS) begin
            w = tmask_q[idx];
        end else begin
            w = tpol_q[idx - NUM_TERMS];
        end
        term_word = 32'(w);
    endfunction

    function automatic logic addr_is_route(input logic [7:0] a);
        addr_is_route = (a[7:6] == 2'b11) && (a[1:0] == 2'b00);
    endfunction

    always_ff @(posedge pclk or negedge presetn) begin
        int ti;
        if (!presetn) begin
            mode_q <= cpld_mode_t'(CPLD_MODE_RST);
            sel0_q <= CPLD_SEL_RST;
            sel1_q <= CPLD_SEL_RST;
            sig_q  <= CPLD_SIG_RST;
            fuse_q <= 1'b0;
            for (int i = 0; i < NUM_TERMS; i++) begin
                tmask_q[i] <= BLK_IN'(CPLD_TMASK_RST);
                tpol_q[i]  <= BLK_IN'(CPLD_TMASK_RST);
            end
        end else if (clk_en && wr_en) begin
            // once the fuse is blown the configuration is frozen; signature stays writable
            if (fuse_q == 1'b0) begin
                if (paddr == CPLD_ADDR_MODE) begin
                    mode_q <= cpld_mode_t'(pwdata);
                end else if (paddr == CPLD_ADDR_SEL0) begin
                    sel0_q <= pwdata;
                end else if (paddr == CPLD_ADDR_SEL1) begin
                    sel1_q <= pwdata;
                end else if (paddr == CPLD_ADDR_FUSE) begin
                    fuse_q <= pwdata[0];
                end else if (addr_is_term(paddr, ti)) begin
                    if (ti < NUM_TERMS) begin
                        tmask_q[ti] <= BLK_IN'(pwdata);
                    end else begin
                        tpol_q[ti - NUM_TERMS] <= BLK_IN'(pwdata);
                    end
                end
            end
            if (paddr == CPLD_ADDR_SIG) begin
                sig_q <= pwdata[CPLD_SIG_W-1:0];
            end
        end
    end

    // ========================================================================
    // switch matrix: each of the block inputs picks one global bus line
    // wide enough to reach every bus line; codes past the bus read as low
    localparam int ROUTE_W = $clog2(GBUS_W);
    logic [BLK_IN-1:0]  blk_in;
    logic [ROUTE_W-1:0] route_q [BLK_IN];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < BLK_IN; i++) begin
                route_q[i] <= ROUTE_W'(i);
            end
        end else if (clk_en && wr_en && !fuse_q && addr_is_route(paddr)) begin
            route_q[paddr[5:2]] <= pwdata[ROUTE_W-1:0];
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < BLK_IN; gi++) begin : g_route
            assign blk_in[gi] = (32'(route_q[gi]) < GBUS_W) ? global_bus[route_q[gi]]
                                                              : 1'b0;
        end
    endgenerate

    // ========================================================================
    // product terms: and of selected global and regional literals
    // an empty mask makes a term true; the or mask drops unused terms
    logic [NUM_TERMS-1:0] pt;
    logic [2:0]           fold_mask;

    assign fold_mask = sel1_q[31:29];

    generate
        for (gi = 0; gi < NUM_TERMS; gi++) begin : g_pt
            // regional foldbacks join every term when enabled
            assign pt[gi] = &((blk_in ^ tpol_q[gi]) | ~tmask_q[gi])
                          & (&(regional_fold_in | ~fold_mask) | ~mode_q.fold_sum_en);
        end
    endgenerate

    // ========================================================================
    // term select mux: selects which term feeds each control
    function automatic logic pick(input logic [NUM_TERMS-1:0] t, input logic [2:0] s);
        pick = (s < 3'(NUM_TERMS)) ? t[s] : 1'b0;
    endfunction

    logic pt_xor, pt_din, pt_clk, pt_ce, pt_clr, pt_pre, pt_oe, pt_fold;
    assign pt_xor  = pick(pt, sel0_q[2:0]);
    assign pt_din  = pick(pt, sel0_q[5:3]);
    assign pt_clk  = pick(pt, sel0_q[8:6]);
    assign pt_ce   = pick(pt, sel0_q[11:9]);
    assign pt_clr  = pick(pt, sel0_q[14:12]);
    assign pt_pre  = pick(pt, sel0_q[17:15]);
    assign pt_oe   = pick(pt, sel0_q[20:18]);
    assign pt_fold = pick(pt, sel0_q[23:21]);

    // ========================================================================
    // or / xor / cascade; the chain of eight cells gives the forty-term limit
    logic or_sum, xor_out, fold_sum;
    assign or_sum  = |(pt & mode_q.or_mask) | (mode_q.cascade_en & cascade_in);
    assign cascade_out = or_sum;
    assign fold_out    = ~pt_fold;
    // three regional foldbacks plus the local one: four-term sum
    assign fold_sum    = |regional_fold_in | fold_out;

    always_comb begin
        xor_out = or_sum;
        case (mode_q.xor_src)
            CPLD_XOR_HIGH: xor_out = ~or_sum;
            CPLD_XOR_PT:   xor_out = or_sum ^ pt_xor;
            default:       xor_out = or_sum;
        endcase
    end

    // ========================================================================
    // register data, sampled clocks and async controls
    logic din, next_state, clk_sel, clk_sel_q, clk_rise, ce_ok, clr_on, pre_on;

    always_comb begin
        din = xor_out;
        case (mode_q.din_src)
            CPLD_DIN_PT:  din = pt_din;
            CPLD_DIN_PIN: din = io_in;
            default:      din = mode_q.fold_sum_en ? fold_sum : xor_out;
        endcase
    end

    // t cells xor din with the current state; jk uses pt_xor as j and pt_din as k
    always_comb begin
        next_state = din;
        case (mode_q.ff_mode)
            CPLD_FF_T:  next_state = reg_q ^ din;
            CPLD_FF_JK: next_state = (pt_xor & ~reg_q) | (~pt_din & reg_q);
            default:    next_state = din;
        endcase
    end

    // switching source while the old clock is low and the new one high can look like an edge
    always_comb begin
        clk_sel = pt_clk;
        case (mode_q.clk_src)
            3'd0:    clk_sel = ctrl_pins.global_clock_pins[0];
            3'd1:    clk_sel = ctrl_pins.global_clock_pins[1];
            3'd2:    clk_sel = ctrl_pins.global_clock_pins[2];
            default: clk_sel = pt_clk;
        endcase
    end

    // enable applies only with a global clock
    assign ce_ok = !(mode_q.ce_en && mode_q.clk_src < 3'd3 && !pt_ce);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_sel_q <= 1'b0;
        end else if (clk_en) begin
            clk_sel_q <= clk_sel;
        end
    end
    // sampled clock: pins are synchronous to pclk, so edges are found here
    assign clk_rise = clk_sel && !clk_sel_q;

    always_comb begin
        clr_on = 1'b0;
        case (mode_q.async_reset_select)
            CPLD_CLR_GLB:  clr_on = ctrl_pins.global_clear;
            CPLD_CLR_PT:   clr_on = pt_clr;
            CPLD_CLR_BOTH: clr_on = ctrl_pins.global_clear | pt_clr;
            default:       clr_on = 1'b0;
        endcase
    end
    assign pre_on = mode_q.preset_en & pt_pre;

    // clear/preset act in the same cycle through the combinational view below
    // a term clock is sampled too, so its high phase must span a pclk
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reg_q <= 1'b0;
        end else if (clk_en) begin
            if (clr_on) begin
                reg_q <= 1'b0;
            end else if (pre_on) begin
                reg_q <= 1'b1;
            end else if (mode_q.ff_mode == CPLD_FF_LATCH) begin
                if (clk_sel && ce_ok) begin
                    reg_q <= din;
                end
            end else if (clk_rise && ce_ok) begin
                reg_q <= next_state;
            end
        end
    end

    logic reg_view, latch_view;
    assign latch_view = (mode_q.ff_mode == CPLD_FF_LATCH && clk_sel && ce_ok) ? din
                      : reg_q;
    assign reg_view   = clr_on ? 1'b0 : (pre_on ? 1'b1 : latch_view);

    // ========================================================================
    // output, feedback and output enable
    logic comb_val, oe_val;
    assign comb_val = xor_out;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            io_out       <= 1'b0;
            feedback_out <= 1'b0;
            io_oe        <= 1'b0;
        end else if (clk_en) begin
            io_out       <= mode_q.out_reg ? reg_view : comb_val;
            feedback_out <= mode_q.fb_reg  ? reg_view : comb_val;
            io_oe        <= oe_val;
        end
    end

    // code 0 keeps the pin an input; feedback and cascade stay usable
    always_comb begin
        oe_val = 1'b0;
        case (mode_q.oe_src)
            3'd1:    oe_val = ctrl_pins.oe_pins[0] ^ mode_q.oe_invert;
            3'd2:    oe_val = ctrl_pins.oe_pins[1] ^ mode_q.oe_invert;
            3'd3:    oe_val = oe_extra_in[0];
            3'd4:    oe_val = oe_extra_in[1];
            3'd5:    oe_val = pt_oe;
            3'd6:    oe_val = 1'b1;
            default: oe_val = 1'b0;                                     // input only
        endcase
    end

    // ========================================================================
    // read path; signature is never hidden by the fuse
    // loading in the setup cycle lets every access finish without a wait
    always_ff @(posedge pclk or negedge presetn) begin
        int rd_ti;
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (clk_en && psel && !penable) begin
            pslverr <= 1'b0;
            if (paddr == CPLD_ADDR_SIG) begin
                prdata <= {16'h0000, sig_q};
            end else if (fuse_q && !pwrite) begin
                prdata <= 32'h0000_0000;
            end else if (paddr == CPLD_ADDR_MODE) begin
                prdata <= mode_q;
            end else if (paddr == CPLD_ADDR_SEL0) begin
                prdata <= sel0_q;
            end else if (paddr == CPLD_ADDR_SEL1) begin
                prdata <= sel1_q;
            end else if (paddr == CPLD_ADDR_STATUS) begin
                prdata <= {26'h000_0000,
                           or_sum,
                           |pt,
                           io_oe,
                           feedback_out,
                           io_out,
                           reg_q};
            end else if (paddr == CPLD_ADDR_FUSE) begin
                prdata <= {31'h0000_0000, fuse_q};
            end else if (addr_is_term(paddr, rd_ti)) begin
                prdata <= term_word(rd_ti);
            end else if (addr_is_route(paddr)) begin
                prdata <= 32'(route_q[paddr[5:2]]);
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    logic unused_rd;
    assign unused_rd = rd_en;

endmodule // cpld_macrocell
`default_nettype wire

// [cpld_macrocell_sva.sv]
// checker: bus handshake, lock, signature and freeze assertions for the macrocell
`default_nettype none
module cpld_macrocell_sva
    import cpld_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        clk_en,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        io_out,
    input wire logic        io_oe,
    input wire logic        feedback_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========
    // shadows of the lock and the signature, so that reads can be judged
    logic        fuse_q;
    logic [15:0] sig_q;
    wire logic   wr_acc = psel && penable && pwrite && clk_en;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fuse_q <= 1'b0;
        end else if (wr_acc && !fuse_q && paddr == CPLD_ADDR_FUSE) begin
            fuse_q <= pwdata[0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sig_q <= CPLD_SIG_RST;
        end else if (wr_acc && paddr == CPLD_ADDR_SIG) begin
            sig_q <= pwdata[15:0];
        end
    end

    // ==========
    // properties
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence rd_acc(logic [7:0] a);
        psel && penable && !pwrite && paddr == a;
    endsequence
    sequence rd_hole;
        psel && penable && !pwrite && paddr inside {[8'h48:8'hbc]};
    endsequence

    zero_wait_a: assert property (psel && !penable |=> pready)
        else $error("access phase not answered");
    no_error_a: assert property (psel && penable |-> !pslverr)
        else $error("slave error raised");
    rdata_hold_a: assert property (psel && penable |=> $stable(prdata))
        else $error("read data moved after access");
    hole_read_a: assert property (rd_hole |-> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    sig_read_a: assert property (rd_acc(CPLD_ADDR_SIG) |-> prdata[15:0] == sig_q)
        else $error("signature read mismatch");
    lock_read_a: assert property (fuse_q && psel && penable && !pwrite
        && paddr != CPLD_ADDR_SIG |-> prdata == 32'h0000_0000)
        else $error("locked read leaked data");
    outputs_frozen_a: assert property (!clk_en |=> $stable({io_out, io_oe, feedback_out}))
        else $error("outputs moved while frozen");
    reset_out_a: assert property ($rose(presetn) |-> !io_out && !io_oe && !feedback_out)
        else $error("outputs not cleared by reset");
endmodule // cpld_macrocell_sva

bind cpld_macrocell cpld_macrocell_sva chk_u (
    .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .io_out, .io_oe, .feedback_out
);
`default_nettype wire

// [tb_cpld_macrocell_logic.sv]
// testbench: random and directed checks of the macrocell through apb and pins
`default_nettype none
module tb_cpld_macrocell_logic
    import cpld_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SETTLE = 6;
    logic                   pclk, presetn, clk_en, psel, penable, pwrite, io_in, cascade_in, b, e;
    logic [7:0]             paddr;
    logic [31:0]            pwdata, prdata, v, r;
    logic                   pready, pslverr, cascade_out, fold_out, feedback_out, io_out, io_oe;
    logic [CPLD_GBUS_W-1:0] gbus;
    logic [2:0]             fold_in;
    logic [1:0]             oe_extra;
    cpld_ctrl_t             ctrl;
    cpld_mode_t             m;
    int                     failures, comparisons;

    always #10 pclk = ~pclk;

    cpld_macrocell dut_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ctrl_pins(ctrl), .global_bus(gbus),
        .regional_fold_in(fold_in), .cascade_in(cascade_in), .oe_extra_in(oe_extra),
        .cascade_out(cascade_out), .fold_out(fold_out), .feedback_out(feedback_out),
        .io_out(io_out), .io_oe(io_oe), .io_in(io_in));

    // ==========
    // reporting and bus tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // one idle edge first, so back-to-back calls never drive psel twice in a step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        if (n >= 64) begin
            failures++;
            end_of_test();
        end
        v = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(v, exp);
    endtask

    task automatic settle();
        repeat (SETTLE) @(posedge pclk);
    endtask

    task automatic cfg();
        apb(1'b1, CPLD_ADDR_MODE, 32'(m));
        settle();
    endtask

    task automatic pin_pulse(input int i);
        ctrl.global_clock_pins[i] <= 1'b1;
        settle();
        ctrl.global_clock_pins[i] <= 1'b0;
        settle();
    endtask

    function automatic logic exp_oe(input logic [2:0] s, input logic i);
        case (s)
            3'd1: return ctrl.oe_pins[0] ^ i;
            3'd2: return ctrl.oe_pins[1] ^ i;
            3'd3: return oe_extra[0];
            3'd4: return oe_extra[1];
            3'd5: return r[20:18] < 3'd5;
            3'd6: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    // ==========
    // main sequence
    initial begin
        {pclk, presetn, psel, penable, pwrite, io_in, cascade_in} = '0;
        clk_en = 1'b1;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        ctrl = '0;
        failures = 0;
        comparisons = 0;
        v = $urandom(63699);
        gbus = CPLD_GBUS_W'({$urandom, $urandom, $urandom});
        fold_in = 3'($urandom);
        oe_extra = 2'($urandom);
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        chk(32'(io_oe), 32'h0000_0000);
        rd(CPLD_ADDR_MODE, CPLD_MODE_RST);
        rd(CPLD_ADDR_SEL0, CPLD_SEL_RST);
        rd(CPLD_ADDR_TMASK, CPLD_TMASK_RST);
        rd(8'h80, 32'h0000_0000);
        for (int k = 0; k < 4; k++) begin
            r = $urandom & 32'h00ff_ffff;
            apb(1'b1, CPLD_ADDR_SEL0, r);
            rd(CPLD_ADDR_SEL0, r);
            chk(32'(fold_out), 32'(r[23:21] > 3'd4));
        end
        m = '0;
        for (int k = 0; k < 10; k++) begin
            m.oe_src = (k % 6 == 0) ? 3'd6 : 3'(k % 6);
            m.oe_invert = (m.oe_src inside {3'd1, 3'd2}) ? 1'($urandom) : 1'b0;
            ctrl.oe_pins <= 2'($urandom);
            oe_extra <= 2'($urandom);
            cfg();
            chk(32'(io_oe), 32'(exp_oe(m.oe_src, m.oe_invert)));
        end
        // combinational path: empty sum, polarity from the fixed xor input
        for (int k = 0; k < 2; k++) begin
            m.xor_src = k ? CPLD_XOR_HIGH : CPLD_XOR_LOW;
            cfg();
            chk(32'(io_out), 32'(k));
            chk(32'(feedback_out), 32'(k));
        end
        m.cascade_en = 1'b1;
        for (int k = 0; k < 2; k++) begin
            cascade_in <= 1'(k);
            cfg();
            chk(32'(cascade_out), 32'(k));
        end
        m.cascade_en = 1'b0;
        m.ff_mode = CPLD_FF_D;
        m.din_src = CPLD_DIN_PIN;
        m.out_reg = 1'b1;
        m.xor_src = CPLD_XOR_HIGH;
        for (int k = 0; k < 6; k++) begin
            m.clk_src = 3'(k % 3);
            b = ~1'(k);
            io_in <= b;
            cfg();
            pin_pulse(k % 3);
            chk(32'(io_out), 32'(b));
            chk(32'(feedback_out), 32'h0000_0001);
            io_in <= ~b;
            settle();
            chk(32'(io_out), 32'(b));
        end
        m.ff_mode = CPLD_FF_LATCH;
        m.clk_src = 3'd0;
        cfg();
        ctrl.global_clock_pins[0] <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            io_in <= 1'(k);
            settle();
            chk(32'(io_out), 32'(k));
        end
        ctrl.global_clock_pins[0] <= 1'b0;
        settle();
        io_in <= 1'b0;
        settle();
        chk(32'(io_out), 32'h0000_0001);
        m.ff_mode = CPLD_FF_T;
        m.din_src = CPLD_DIN_XOR;
        cfg();
        e = 1'b1;
        for (int k = 0; k < 2; k++) begin
            pin_pulse(0);
            e = ~e;
            chk(32'(io_out), 32'(e));
        end
        // frozen core must ignore a clock pulse
        clk_en <= 1'b0;
        pin_pulse(0);
        clk_en <= 1'b1;
        settle();
        chk(32'(io_out), 32'(e));
        m.ff_mode = CPLD_FF_D;
        m.din_src = CPLD_DIN_PIN;
        for (int k = 0; k < 3; k++) begin
            m.async_reset_select = (k == 0) ? CPLD_CLR_OFF
                                 : (k == 1) ? CPLD_CLR_GLB : CPLD_CLR_BOTH;
            io_in <= 1'b1;
            cfg();
            pin_pulse(0);
            ctrl.global_clear <= 1'b1;
            settle();
            chk(32'(io_out), 32'(k == 0));
            ctrl.global_clear <= 1'b0;
        end
        // all selects on term 0, which is true: preset alone, then with clear
        apb(1'b1, CPLD_ADDR_SEL0, 32'h0000_0000);
        m.preset_en = 1'b1;
        for (int k = 0; k < 2; k++) begin
            m.async_reset_select = k ? CPLD_CLR_PT : CPLD_CLR_OFF;
            cfg();
            chk(32'(io_out), 32'(k == 0));
        end
        r = 32'($urandom_range(0, 65535));
        apb(1'b1, CPLD_ADDR_SIG, r);
        apb(1'b1, CPLD_ADDR_FUSE, 32'h0000_0001);
        rd(CPLD_ADDR_MODE, 32'h0000_0000);
        rd(CPLD_ADDR_SIG, r);
        apb(1'b1, CPLD_ADDR_SIG, ~r & 32'h0000_ffff);
        rd(CPLD_ADDR_SIG, ~r & 32'h0000_ffff);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        chk(32'({io_out, io_oe}), 32'h0000_0000);
        rd(CPLD_ADDR_SIG, 32'(CPLD_SIG_RST));
        end_of_test();
    end
endmodule // tb_cpld_macrocell_logic
`default_nettype wire
